// >>> hdl/rtc_pkg.sv
// Constants for the calendar clock with alarm.
package rtc_pkg;
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_IEN = 4'h0;
   localparam logic [3:0] OFS_CTRL = 4'h1;
   localparam logic [3:0] OFS_STAT = 4'h2;
   localparam logic [3:0] OFS_ALM_MIN = 4'h3;
   localparam logic [3:0] OFS_ALM_HR = 4'h4;
   localparam logic [3:0] OFS_SEC = 4'h5;
   localparam logic [3:0] OFS_MIN = 4'h6;
   localparam logic [3:0] OFS_HR = 4'h7;
   localparam logic [3:0] OFS_DAY = 4'h8;
   localparam logic [3:0] OFS_MTH = 4'h9;
   localparam logic [3:0] OFS_YR = 4'ha;
   localparam logic [3:0] OFS_DOW = 4'hb;
   localparam logic [3:0] OFS_CHR = 4'hc;
   localparam int B_ALM = 7;
   localparam int B_CHR = 6;
   localparam int B_DAY = 5;
   localparam int B_HR = 4;
   localparam int B_MIN = 3;
   localparam int B_SEC = 2;
   localparam int B_HALF = 1;
   localparam int B_QUART = 0;
   localparam int B_MOD_EN = 7;
   localparam int B_CHR_EN = 6;
   localparam int B_CHR_CLR = 5;
   localparam logic [14:0] QDIV_32K = 15'h2000;
   localparam logic [14:0] QDIV_32 = 15'h1f40;
   localparam logic [14:0] QDIV_38 = 15'h2580;
   localparam logic [14:0] QDIV_64 = 15'h3e80;
   localparam logic [14:0] QDIV_76 = 15'h4b00;
   localparam logic [9:0] CDIV_32K = 10'h100;
   localparam logic [9:0] CDIV_32 = 10'h140;
   localparam logic [9:0] CDIV_38 = 10'h180;
   localparam logic [9:0] CDIV_64 = 10'h280;
   localparam logic [9:0] CDIV_76 = 10'h300;
   localparam logic [7:0] CONV_ADD = 8'h64;
   localparam logic [7:0] CONV_MOD = 8'h80;
   localparam logic [7:0] SEC_MAX = 8'h3b;
   localparam logic [7:0] HR_MAX = 8'h17;
   localparam logic [7:0] MTH_MAX = 8'h0c;
   localparam logic [7:0] YR_MAX = 8'hc7;
   localparam logic [7:0] DOW_MAX = 8'h06;
   localparam logic [7:0] CHR_MAX = 8'h63;
   localparam logic [7:0] FIRST = 8'h01;
   localparam logic [7:0] FEB = 8'h02;
   localparam logic [7:0] APR = 8'h04;
   localparam logic [7:0] JUN = 8'h06;
   localparam logic [7:0] SEP = 8'h09;
   localparam logic [7:0] NOV = 8'h0b;
   localparam logic [7:0] DAYS_28 = 8'h1c;
   localparam logic [7:0] DAYS_29 = 8'h1d;
   localparam logic [7:0] DAYS_30 = 8'h1e;
   localparam logic [7:0] DAYS_31 = 8'h1f;
endpackage

// >>> hdl/calendar_clock_with_alarm.sv
// Calendar clock with alarm, timebase ticks and chronograph.
// Summary of operation
// - Second, minute, hour increments set flags; enabled flags request interrupts.
// - Counter reads return current value; writes load and counting continues.
// - Day of month rolls over per month length and leap year.
// - Years 1901 to 2099 are held, leap years handled throughout.
// - Each day increment sets the day flag; enabled, it interrupts.
// - Minute and hour matching the alarm set the alarm flag.
// - Divider gives 2 Hz and 4 Hz ticks setting two timebase flags.
// - Enabled chronograph counts hundredths and wraps to zero after 99.
// - At 32.768 kHz chronograph runs 128 Hz, converted to 10 ms steps.
// - Crystal select picks prescalers dividing the reference down to 1 Hz.
// - In wait mode the block runs and enabled requests wake the processor.
// - With oscillator kept in stop, block runs and requests wake.
// - Without it, stop freezes the block, registers kept, resumes afterwards.
// - First control register holds eight interrupt enables, cleared by reset.
// - Chronograph clear bit zeroes only the chronograph, self-clears, reads 0.
// - Chronograph counts while enabled, holds when disabled; reset disables.
// - Module enable gates all counting, keeps registers, reset clears it.
// - Crystal codes: 000 32.768, 010 32.0, 011 38.4, 1X0 64.0, 1X1 76.8 kHz.
// - Crystal select accepts only the first write after reset.
// - Flag clears by status read while set, then its data register read.
// - Seconds and minutes wrap after 59; writes above 59 ignored.
`timescale 1ns/1ps
module calendar_clock_with_alarm #(
   parameter int ADDR_W = rtc_pkg::ADDR_W
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic reference_osc_clock,
   input wire logic stop_mode,
   input wire logic osc_in_stop_enable,
   output logic irq,
   output logic wake_request
);
   import rtc_pkg::*;

   if (ADDR_W < 4) begin : g_chk
      $error("Address width must be at least 4.");
   end

   logic [7:0] ien_r, flag_r, arm_r;
   logic mod_en_r, chr_en_r, xtl_wr_r, ref_prev_r, match_r;
   logic [2:0] xtl_r;
   logic [7:0] alm_min_r, alm_hr_r, sec_r, min_r, hr_r;
   logic [7:0] day_r, mth_r, yr_r, dow_r, chr_r, conv_r;
   logic [14:0] qcnt_r;
   logic [1:0] qph_r;
   logic [9:0] ccnt_r;

   function automatic logic [7:0] dim(input logic [7:0] m, input logic [7:0] y);
      if (m == FEB) begin
         dim = (y[1:0] == 2'b00) ? DAYS_29 : DAYS_28;
      end else if (m == APR || m == JUN || m == SEP || m == NOV) begin
         dim = DAYS_30;
      end else begin
         dim = DAYS_31;
      end
   endfunction

   // Register decode.
   wire logic sel_ien = addr == ADDR_W'(OFS_IEN);
   wire logic sel_ctrl = addr == ADDR_W'(OFS_CTRL);
   wire logic sel_stat = addr == ADDR_W'(OFS_STAT);
   wire logic sel_amin = addr == ADDR_W'(OFS_ALM_MIN);
   wire logic sel_ahr = addr == ADDR_W'(OFS_ALM_HR);
   wire logic sel_sec = addr == ADDR_W'(OFS_SEC);
   wire logic sel_min = addr == ADDR_W'(OFS_MIN);
   wire logic sel_hr = addr == ADDR_W'(OFS_HR);
   wire logic sel_day = addr == ADDR_W'(OFS_DAY);
   wire logic sel_mth = addr == ADDR_W'(OFS_MTH);
   wire logic sel_yr = addr == ADDR_W'(OFS_YR);
   wire logic sel_dow = addr == ADDR_W'(OFS_DOW);
   wire logic sel_chr = addr == ADDR_W'(OFS_CHR);
   wire logic wr_ctrl = wr & sel_ctrl;
   wire logic chr_clr = wr_ctrl & wdata[B_CHR_CLR];
   wire logic [7:0] dim_now = dim(mth_r, yr_r);
   wire logic [7:0] dim_wr = dim(wdata, yr_r);

   // Out-of-range writes to time and date counters are dropped.
   wire logic wr_sec = wr & sel_sec & (wdata <= SEC_MAX);
   wire logic wr_min = wr & sel_min & (wdata <= SEC_MAX);
   wire logic wr_hr = wr & sel_hr & (wdata <= HR_MAX);
   wire logic wr_day = wr & sel_day & (wdata >= FIRST) & (wdata <= dim_now);
   wire logic wr_mth = wr & sel_mth & (wdata >= FIRST) & (wdata <= MTH_MAX);
   wire logic wr_yr = wr & sel_yr & (wdata >= FIRST) & (wdata <= YR_MAX);
   wire logic wr_dow = wr & sel_dow & (wdata <= DOW_MAX);

   // Stop without the oscillator freezes everything but the bus.
   wire logic active = mod_en_r & ~(stop_mode & ~osc_in_stop_enable);
   wire logic tick = active & reference_osc_clock & ~ref_prev_r;

   // Prescaler selection from the crystal code.
   wire logic is_32k = xtl_r[2:1] == 2'b00;
   wire logic [14:0] qdiv = xtl_r[2] ? (xtl_r[0] ? QDIV_76 : QDIV_64) :
      xtl_r[1] ? (xtl_r[0] ? QDIV_38 : QDIV_32) : QDIV_32K;
   wire logic [9:0] cdiv = xtl_r[2] ? (xtl_r[0] ? CDIV_76 : CDIV_64) :
      xtl_r[1] ? (xtl_r[0] ? CDIV_38 : CDIV_32) : CDIV_32K;

   wire logic q_tick = tick & (qcnt_r == qdiv - 15'h0001);
   wire logic h_tick = q_tick & qph_r[0];
   wire logic s_tick = q_tick & (qph_r == 2'b11);
   wire logic c_raw = tick & (ccnt_r == cdiv - 10'h001);
   wire logic [7:0] conv_sum = conv_r + CONV_ADD;
   // At 128 Hz only 100 of every 128 ticks advance the count.
   wire logic c_step = is_32k ? (c_raw & (conv_sum >= CONV_MOD)) : c_raw;
   wire logic c_inc = c_step & chr_en_r;

   // Calendar cascade.
   wire logic m_tick = s_tick & (sec_r >= SEC_MAX);
   wire logic h_inc = m_tick & (min_r >= SEC_MAX);
   wire logic d_inc = h_inc & (hr_r >= HR_MAX);
   wire logic mo_inc = d_inc & (day_r >= dim_now);
   wire logic y_inc = mo_inc & (mth_r >= MTH_MAX);

   wire logic match = (min_r == alm_min_r) & (hr_r == alm_hr_r);
   wire logic alm_set = active & match & ~match_r;

   wire logic st_rd = rd & sel_stat;
   wire logic [7:0] fset = {alm_set, c_inc, d_inc, h_inc, m_tick, s_tick, h_tick, q_tick};
   wire logic [7:0] drd = {rd & sel_ahr, rd & sel_chr, rd & sel_day, rd & sel_hr,
      rd & sel_min, rd & sel_sec, rd & sel_chr, rd & sel_chr};
   wire logic [7:0] flag_nxt, arm_nxt;

   // A new event wins over a clear in the same cycle.
   for (genvar i = 0; i < 8; i++) begin : g_flag
      assign flag_nxt[i] = fset[i] | (flag_r[i] & ~(arm_r[i] & drd[i]));
      assign arm_nxt[i] = (st_rd & flag_r[i]) | (arm_r[i] & ~drd[i]);
   end

   wire logic req = |(flag_r & ien_r);
   wire logic [7:0] ctrl_rd = {mod_en_r, chr_en_r, 3'b000, xtl_r};
   wire logic [7:0] rd_mux = sel_ien ? ien_r : sel_ctrl ? ctrl_rd :
      sel_stat ? flag_r : sel_amin ? alm_min_r : sel_ahr ? alm_hr_r :
      sel_sec ? sec_r : sel_min ? min_r : sel_hr ? hr_r :
      sel_day ? day_r : sel_mth ? mth_r : sel_yr ? yr_r :
      sel_dow ? dow_r : sel_chr ? chr_r : 8'h00;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata <= 8'h00;
         irq <= 1'b0;
         wake_request <= 1'b0;
         flag_r <= 8'h00;
         arm_r <= 8'h00;
         match_r <= 1'b0;
         ref_prev_r <= 1'b0;
      end else begin
         rdata <= rd ? rd_mux : 8'h00;
         irq <= req;
         wake_request <= req & (~stop_mode | osc_in_stop_enable);
         flag_r <= flag_nxt;
         arm_r <= arm_nxt;
         match_r <= match;
         ref_prev_r <= reference_osc_clock;
      end
   end

   // Control registers.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ien_r <= 8'h00;
         mod_en_r <= 1'b0;
         chr_en_r <= 1'b0;
         xtl_r <= 3'b000;
         xtl_wr_r <= 1'b0;
         alm_min_r <= 8'h00;
         alm_hr_r <= 8'h00;
      end else begin
         if (wr & sel_ien) begin
            ien_r <= wdata;
         end
         if (wr_ctrl) begin
            mod_en_r <= wdata[B_MOD_EN];
            chr_en_r <= wdata[B_CHR_EN];
            xtl_wr_r <= 1'b1;
         end
         if (wr_ctrl & ~xtl_wr_r) begin
            xtl_r <= wdata[2:0];
         end
         if (wr & sel_amin) begin
            alm_min_r <= wdata;
         end
         if (wr & sel_ahr) begin
            alm_hr_r <= wdata;
         end
      end
   end

   // Prescalers run only while the block is active.
   always_ff @(posedge clk) begin
      if (!resetn || chr_clr) begin
         ccnt_r <= 10'h000;
         conv_r <= 8'h00;
      end else if (c_raw) begin
         ccnt_r <= 10'h000;
         conv_r <= (is_32k && conv_sum >= CONV_MOD) ? conv_sum - CONV_MOD :
            (is_32k ? conv_sum : 8'h00);
      end else if (tick) begin
         ccnt_r <= ccnt_r + 10'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         qcnt_r <= 15'h0000;
         qph_r <= 2'b00;
      end else if (q_tick) begin
         qcnt_r <= 15'h0000;
         qph_r <= qph_r + 2'b01;
      end else if (tick) begin
         qcnt_r <= qcnt_r + 15'h0001;
      end
   end

   // Chronograph: clear wins, then count with wrap.
   always_ff @(posedge clk) begin
      if (!resetn || chr_clr) begin
         chr_r <= 8'h00;
      end else if (c_inc) begin
         chr_r <= (chr_r >= CHR_MAX) ? 8'h00 : chr_r + 8'h01;
      end
   end

   // Time of day; a valid write overrides a same-cycle increment.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         sec_r <= 8'h00;
         min_r <= 8'h00;
         hr_r <= 8'h00;
      end else begin
         if (wr_sec) begin
            sec_r <= wdata;
         end else if (s_tick) begin
            sec_r <= m_tick ? 8'h00 : sec_r + 8'h01;
         end
         if (wr_min) begin
            min_r <= wdata;
         end else if (m_tick) begin
            min_r <= h_inc ? 8'h00 : min_r + 8'h01;
         end
         if (wr_hr) begin
            hr_r <= wdata;
         end else if (h_inc) begin
            hr_r <= d_inc ? 8'h00 : hr_r + 8'h01;
         end
      end
   end

   // Calendar; year holds the year minus 1900.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         day_r <= FIRST;
         mth_r <= FIRST;
         yr_r <= FIRST;
         dow_r <= 8'h00;
      end else begin
         if (wr_day) begin
            day_r <= wdata;
         end else if (d_inc) begin
            day_r <= mo_inc ? FIRST : day_r + 8'h01;
         end
         if (wr_mth && wdata != mth_r && day_r > dim_wr) begin
            mth_r <= mth_r;
         end else if (wr_mth) begin
            mth_r <= wdata;
         end else if (mo_inc) begin
            mth_r <= y_inc ? FIRST : mth_r + 8'h01;
         end
         if (wr_yr) begin
            yr_r <= wdata;
         end else if (y_inc) begin
            yr_r <= (yr_r >= YR_MAX) ? FIRST : yr_r + 8'h01;
         end
         if (wr_dow) begin
            dow_r <= wdata;
         end else if (d_inc) begin
            dow_r <= (dow_r >= DOW_MAX) ? 8'h00 : dow_r + 8'h01;
         end
      end
   end

   a_irq_gate: assert property (@(posedge clk) disable iff (!resetn)
      req |=> irq) else $error("Enabled flag gave no interrupt.");
   a_irq_quiet: assert property (@(posedge clk) disable iff (!resetn)
      !req |=> !irq) else $error("Interrupt without enabled flag.");
   a_sec_roll: assert property (@(posedge clk) disable iff (!resetn)
      s_tick && sec_r == SEC_MAX && !wr_sec |=> sec_r == 8'h00 && flag_r[B_MIN])
      else $error("Second rollover wrong.");
   a_sec_reject: assert property (@(posedge clk) disable iff (!resetn)
      wr && sel_sec && wdata > SEC_MAX && !s_tick |=> $stable(sec_r))
      else $error("Bad second write taken.");
   a_leap_feb: assert property (@(posedge clk) disable iff (!resetn)
      d_inc && mth_r == FEB && yr_r[1:0] == 2'b00 && day_r == DAYS_28 && !wr
      |=> day_r == DAYS_29 && mth_r == FEB) else $error("Leap day skipped.");
   a_chr_wrap: assert property (@(posedge clk) disable iff (!resetn)
      c_inc && chr_r == CHR_MAX && !chr_clr |=> chr_r == 8'h00)
      else $error("Chronograph did not wrap.");
   a_chr_hold: assert property (@(posedge clk) disable iff (!resetn)
      !chr_en_r && !chr_clr |=> $stable(chr_r)) else $error("Chronograph moved.");
   a_chr_clear: assert property (@(posedge clk) disable iff (!resetn)
      chr_clr |=> chr_r == 8'h00 ##1 !ctrl_rd[B_CHR_CLR])
      else $error("Chronograph clear failed.");
   a_off_hold: assert property (@(posedge clk) disable iff (!resetn)
      !mod_en_r && !wr |=> $stable({sec_r, min_r, hr_r, day_r}))
      else $error("Counters moved while disabled.");
   a_xtl_once: assert property (@(posedge clk) disable iff (!resetn)
      xtl_wr_r |=> $stable(xtl_r)) else $error("Crystal select rewritten.");
   a_flag_clear: assert property (@(posedge clk) disable iff (!resetn)
      arm_r[B_SEC] && rd && sel_sec && !s_tick |=> !flag_r[B_SEC])
      else $error("Second flag not cleared.");
   a_alarm_set: assert property (@(posedge clk) disable iff (!resetn)
      active && match && !match_r |=> flag_r[B_ALM]) else $error("Alarm missed.");

   a_quarter_tick: assert property (@(posedge clk) disable iff (!resetn)
      q_tick |=> flag_r[B_QUART])
      else $error("Quarter second flag missed.");
   a_half_tick: assert property (@(posedge clk) disable iff (!resetn)
      q_tick && qph_r[0] |=> flag_r[B_HALF])
      else $error("Half second flag missed.");
   a_sec_flag: assert property (@(posedge clk) disable iff (!resetn)
      s_tick |=> flag_r[B_SEC])
      else $error("Second flag missed.");
   a_hour_flag: assert property (@(posedge clk) disable iff (!resetn)
      h_inc |=> flag_r[B_HR])
      else $error("Hour flag missed.");
   a_day_flag: assert property (@(posedge clk) disable iff (!resetn)
      d_inc |=> flag_r[B_DAY])
      else $error("Day flag missed.");
   a_chr_flag: assert property (@(posedge clk) disable iff (!resetn)
      c_inc |=> flag_r[B_CHR])
      else $error("Chronograph flag missed.");
   a_conv_rate: assert property (@(posedge clk) disable iff (!resetn)
      c_raw && is_32k && chr_en_r |-> c_inc == (conv_sum >= CONV_MOD))
      else $error("Chronograph conversion wrong.");
   a_ien_write: assert property (@(posedge clk) disable iff (!resetn)
      wr && sel_ien |=> ien_r == $past(wdata))
      else $error("Interrupt enable write lost.");
   a_read_sec: assert property (@(posedge clk) disable iff (!resetn)
      rd && sel_sec |=> rdata == $past(sec_r))
      else $error("Second read wrong.");
   a_read_idle: assert property (@(posedge clk) disable iff (!resetn)
      !rd |=> rdata == 8'h00)
      else $error("Read data outside read cycle.");
   a_stop_frozen: assert property (@(posedge clk) disable iff (!resetn)
      stop_mode && !osc_in_stop_enable |-> !tick)
      else $error("Block ran in stop.");
   a_wake_stop: assert property (@(posedge clk) disable iff (!resetn)
      stop_mode && !osc_in_stop_enable |=> !wake_request)
      else $error("Wake while frozen.");
   a_wake_run: assert property (@(posedge clk) disable iff (!resetn)
      req && (!stop_mode || osc_in_stop_enable) |=> wake_request)
      else $error("Wake request missing.");
   a_year_wrap: assert property (@(posedge clk) disable iff (!resetn)
      y_inc && yr_r == YR_MAX && !wr |=> yr_r == FIRST)
      else $error("Year wrap wrong.");
   a_min_reject: assert property (@(posedge clk) disable iff (!resetn)
      wr && sel_min && wdata > SEC_MAX && !m_tick |=> $stable(min_r))
      else $error("Bad minute write taken.");
   a_month_roll: assert property (@(posedge clk) disable iff (!resetn)
      mo_inc && mth_r == MTH_MAX && !wr |=> mth_r == FIRST && day_r == FIRST)
      else $error("Year end rollover wrong.");
   a_dow_wrap: assert property (@(posedge clk) disable iff (!resetn)
      d_inc && dow_r == DOW_MAX && !wr |=> dow_r == 8'h00)
      else $error("Weekday wrap wrong.");

endmodule

// >>> verification/ref_osc_model.sv
// Reference oscillator model that feeds the clock block and halts in stop mode unless osc_in_stop_enable is set.
`timescale 1ns/1ps
module ref_osc_model (
   input wire logic clk,
   input wire logic stop_mode,
   input wire logic osc_in_stop_enable,
   output logic reference_osc_clock
);
   logic osc_run;
   // The oscillator keeps running in stop only when it is configured to.
   assign osc_run = !stop_mode || osc_in_stop_enable;
   initial reference_osc_clock = 1'b0;
   // The fastest legal reference, one rising edge every two cycles.
   always @(posedge clk) begin
      if (osc_run) begin
         reference_osc_clock <= !reference_osc_clock;
      end
   end
endmodule

// >>> verification/calendar_clock_with_alarm_bench.sv
// Self-checking bench for the calendar clock with alarm.
`timescale 1ns/1ps
module calendar_clock_with_alarm_bench;
   import rtc_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic stop_mode = 1'b0;
   logic osc_in_stop_enable = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, got, prev, sval;
   logic irq, wake_request, reference_osc_clock;
   int err_total = 0;
   int samples_checked = 0;
   int seed = 90359;
   int i;
   bit seen_sec, seen_wrap;
   logic [3:0] rst_ofs [12] = '{OFS_IEN, OFS_CTRL, OFS_STAT, OFS_SEC, OFS_MIN, OFS_HR, OFS_DAY,
      OFS_MTH, OFS_YR, OFS_DOW, OFS_CHR, 4'hf};
   logic [7:0] rst_val [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01,
      8'h00, 8'h00, 8'h00};
   logic [3:0] set_ofs [11] = '{OFS_ALM_MIN, OFS_ALM_HR, OFS_IEN, OFS_YR, OFS_MTH, OFS_DAY,
      OFS_HR, OFS_MIN, OFS_DOW, OFS_CTRL, OFS_SEC};
   logic [7:0] set_val [11] = '{8'h00, 8'h00, 8'h04, 8'h64, 8'h02, 8'h1c, 8'h17, 8'h3b, 8'h06,
      8'he2, 8'h3b};
   logic [3:0] chk_ofs [8] = '{OFS_SEC, OFS_MIN, OFS_HR, OFS_DAY, OFS_MTH, OFS_YR, OFS_DOW,
      OFS_ALM_HR};
   logic [7:0] chk_val [8] = '{8'h00, 8'h00, 8'h00, 8'h1d, 8'h02, 8'h64, 8'h00, 8'h00};

   calendar_clock_with_alarm uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .reference_osc_clock(reference_osc_clock),
      .stop_mode(stop_mode), .osc_in_stop_enable(osc_in_stop_enable), .irq(irq),
      .wake_request(wake_request));
   ref_osc_model osc (.clk(clk), .stop_mode(stop_mode),
      .osc_in_stop_enable(osc_in_stop_enable), .reference_osc_clock(reference_osc_clock));

   initial begin
      forever #25 clk = ~clk;
   end

   task automatic compare_byte(input logic [7:0] act, input logic [7:0] exp, input string what);
      samples_checked++;
      if (act !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s got %h expected %h", $time, what, act, exp);
      end
   endtask

   task automatic compare_bit(input logic act, input logic exp, input string what);
      samples_checked++;
      if (act !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s got %b expected %b", $time, what, act, exp);
      end
   endtask

   task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask

   task automatic expect_reg(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string w);
      logic [7:0] v;
      bus_read(a, v);
      compare_byte(v, e, w);
   endtask

   task automatic do_reset();
      resetn <= 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
   endtask

   task automatic check_rollover();
      int k;
      bus_read(OFS_STAT, got);
      compare_byte(got & 8'hbf, 8'hbf, "flags at rollover");
      for (k = 0; k < 8; k++) begin
         expect_reg(chk_ofs[k], chk_val[k], "calendar after rollover");
      end
      bus_read(OFS_CHR, got);
      bus_read(OFS_STAT, got);
      compare_byte(got & 8'hbf, 8'h00, "flags after clear reads");
      compare_bit(irq, 1'b0, "irq after clear");
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #(90000 * 50);
      err_total++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      give_verdict();
   end

   initial begin
      @(posedge clk);
      for (i = 0; i < 8; i++) begin
         do_reset();
         bus_write(OFS_CTRL, 8'(i));
         bus_write(OFS_CTRL, 8'(i) ^ 8'h07);
         expect_reg(OFS_CTRL, 8'(i), "crystal select kept");
      end
      $display("test crystal codes done");
      do_reset();
      for (i = 0; i < 12; i++) begin
         expect_reg(rst_ofs[i], rst_val[i], "reset value");
      end
      $display("test reset values done");
      for (i = 0; i < 6; i++) begin
         sval = 8'($random(seed));
         bus_write(OFS_IEN, sval);
         expect_reg(OFS_IEN, sval, "irq enables");
         bus_write(OFS_ALM_MIN, sval);
         expect_reg(OFS_ALM_MIN, sval, "alarm minute");
         sval = (i == 0) ? SEC_MAX + 8'h01 : sval % 8'hc4 + 8'h3c;
         bus_write(OFS_SEC, sval);
         bus_write(OFS_MIN, sval);
         bus_write(OFS_HR, (i == 0) ? HR_MAX + 8'h01 : sval);
         expect_reg(OFS_SEC, 8'h00, "seconds kept");
         expect_reg(OFS_MIN, 8'h00, "minutes kept");
         expect_reg(OFS_HR, 8'h00, "hours kept");
      end
      $display("test register writes done");
      for (i = 0; i < 11; i++) begin
         bus_write(set_ofs[i], set_val[i]);
      end
      expect_reg(OFS_CTRL, 8'hc2, "chrono clear reads zero");
      prev = 8'h00;
      seen_sec = 0;
      seen_wrap = 0;
      for (i = 0; i < 36000 && !(seen_sec && seen_wrap); i++) begin
         bus_read(OFS_CHR, got);
         if (got !== prev) begin
            compare_byte(got, (prev == CHR_MAX) ? 8'h00 : prev + 8'h01, "chrono step");
            seen_wrap |= (prev == CHR_MAX);
            prev = got;
         end
         if (irq === 1'b1 && !seen_sec) begin
            seen_sec = 1;
            check_rollover();
         end
      end
      compare_bit(seen_sec && seen_wrap, 1'b1, "second and chrono wrap seen");
      $display("test rollover done");
      bus_write(OFS_IEN, 8'h40);
      repeat (700) @(posedge clk);
      compare_bit(irq, 1'b1, "chrono irq");
      compare_bit(wake_request, 1'b1, "wake in wait");
      stop_mode <= 1'b1;
      repeat (4) @(posedge clk);
      bus_read(OFS_CHR, sval);
      repeat (1500) @(posedge clk);
      expect_reg(OFS_CHR, sval, "frozen in stop");
      compare_bit(wake_request, 1'b0, "no wake in stop");
      osc_in_stop_enable <= 1'b1;
      repeat (1500) @(posedge clk);
      bus_read(OFS_CHR, got);
      compare_bit(got !== sval, 1'b1, "runs in stop");
      compare_bit(wake_request, 1'b1, "wake in stop");
      stop_mode <= 1'b0;
      osc_in_stop_enable <= 1'b0;
      $display("test low power done");
      // Module off, then chronograph off; the count must hold either way.
      for (i = 0; i < 2; i++) begin
         bus_write(OFS_CTRL, (i == 0) ? 8'h42 : 8'h82);
         repeat (4) @(posedge clk);
         bus_read(OFS_CHR, sval);
         repeat (1500) @(posedge clk);
         expect_reg(OFS_CHR, sval, "count held");
      end
      $display("test enables done");
      give_verdict();
   end
endmodule
